// ---- pkg/dtc_pkg.sv ----
// Package with constants and carrier types for the disk track controller.
package dtc_pkg;
	localparam int PARCEL_W = 16;
	localparam int PACKET_LEN = 16;
	localparam int SECTOR_PARCELS = 2048;
	localparam int SECTORS_PER_TRACK = 48;
	localparam int SPINDLES = 4;
	localparam int SECTORS_PER_SPINDLE = 12;
	localparam int ZERO_RUN_BYTES = 16;
	localparam int ZERO_RUN_PARCELS = ZERO_RUN_BYTES / 2;
	localparam int TRACK_PARCELS = SECTORS_PER_TRACK * SECTOR_PARCELS;
	localparam int ECC_W = 6;
	localparam logic [10:0] LAST_PARCEL = 11'h7FF;
	localparam logic [3:0] LAST_IN_PACKET = 4'hF;
	localparam logic [3:0] LAST_ZERO = 4'h7;
	localparam logic [3:0] SECT_LAST = 4'hB;
	localparam logic [5:0] TRACK_LAST = 6'h2F;
	localparam logic [1:0] SPIN_LAST = 2'h3;

	typedef enum logic [2:0] {
		FN_NOP,
		FN_SELECT,
		FN_SEEK,
		FN_READ,
		FN_WRITE,
		FN_FORMAT,
		FN_STATUS,
		FN_PORT
	} func_t;

	typedef struct packed {
		func_t func;
		logic [15:0] param;
	} chan_func_t;

	typedef struct packed {
		logic [15:0] data;
		logic [5:0] ecc;
	} coded_t;

	typedef struct packed {
		logic valid;
		logic [2:0] func;
		logic [1:0] spindle;
		logic unit;
		logic [15:0] param;
	} drive_ctl_t;
endpackage

// ---- sim/drive_model.sv ----
// Behavioural model of the drive side: stores written words, replays them on read, reports status.
`timescale 1ns/1ps
module drive_model (
	input wire logic clock,
	input wire logic rstn,
	input wire dtc_pkg::drive_ctl_t drv_ctl,
	input wire logic drv_wr_valid,
	input wire dtc_pkg::coded_t drv_wr_word,
	input wire logic drv_wr_last,
	output logic drv_wr_ready,
	output logic drv_rd_valid,
	output dtc_pkg::coded_t drv_rd_word,
	input wire logic drv_rd_ready,
	output logic drv_status_valid,
	output logic [15:0] drv_status,
	input wire logic inj
);
	dtc_pkg::coded_t mem [0:4199];
	dtc_pkg::coded_t last_q;
	dtc_pkg::drive_ctl_t ctl_q;
	int wn;
	int ri;
	int lasts;
	logic rd_on;
	logic [2:0] cnt;
	logic [15:0] stat_q;
	logic [15:0] flip;
	// ****************************************
	// Outputs
	// ****************************************
	// Released lines show the inverse of their last value.
	assign drv_wr_ready = cnt != 3'h0;
	assign flip = !inj ? 16'h0000 : ri == 3 ? 16'h0001 : ri == 4 ? 16'h0003 : 16'h0000;
	assign drv_rd_valid = rd_on && ri < wn;
	assign drv_rd_word = drv_rd_valid ? {mem[ri].data ^ flip, mem[ri].ecc} : ~last_q;
	assign drv_status = drv_status_valid ? stat_q : ~stat_q;
	// ****************************************
	// Storage
	// ****************************************
	always_ff @(posedge clock) begin
		drv_status_valid <= 1'b0;
		if (!rstn) begin
			rd_on <= 1'b0;
			wn <= 0;
			ri <= 0;
			lasts <= 0;
			cnt <= 3'h0;
			last_q <= '0;
			stat_q <= 16'h0000;
		end else begin
			cnt <= cnt + 3'h1;
			if (drv_ctl.valid) begin
				ctl_q <= drv_ctl;
				if (drv_ctl.func == dtc_pkg::FN_WRITE || drv_ctl.func == dtc_pkg::FN_FORMAT) begin
					wn <= 0;
					lasts <= 0;
					rd_on <= 1'b0;
				end
				if (drv_ctl.func == dtc_pkg::FN_READ) begin
					ri <= 0;
					rd_on <= 1'b1;
				end
				if (drv_ctl.func == dtc_pkg::FN_SELECT) begin
					stat_q <= {15'h5280, drv_ctl.unit};
					drv_status_valid <= 1'b1;
				end
			end
			if (drv_wr_valid && drv_wr_ready) begin
				mem[wn] <= drv_wr_word;
				wn <= wn + 1;
				lasts <= lasts + int'(drv_wr_last);
			end
			if (drv_rd_valid && drv_rd_ready) begin
				last_q <= drv_rd_word;
				ri <= ri + 1;
			end
		end
	end
endmodule

// ---- sim/testbench.sv ----
// Self-checking testbench of the disk track controller.
`timescale 1ns/1ps
module testbench;
	logic clock, rstn, fn_valid, acc_valid, dma_in_valid, dma_in_ready, dma_out_valid, dma_out_ready, busy;
	logic drv_status_valid, drv_wr_valid, drv_wr_last, drv_wr_ready, drv_rd_valid, drv_rd_ready;
	logic ecc_fixed, ecc_fatal, inj;
	logic [1:0] acc_chan, port_active;
	logic [15:0] acc_data, dma_in_data, dma_out_data, drv_status;
	logic [15:0] rd_buf [0:2047];
	dtc_pkg::chan_func_t fn_in;
	dtc_pkg::drive_ctl_t drv_ctl;
	dtc_pkg::coded_t drv_wr_word, drv_rd_word;
	int num_errors, compares, fixed_n, fatal_n, acc_n;
	disk_track_controller u_disk_track_controller (.clock(clock), .rstn(rstn), .fn_valid(fn_valid), .fn_in(fn_in),
		.acc_chan(acc_chan), .acc_data(acc_data), .acc_valid(acc_valid), .dma_in_valid(dma_in_valid),
		.dma_in_data(dma_in_data), .dma_in_ready(dma_in_ready), .dma_out_valid(dma_out_valid),
		.dma_out_data(dma_out_data), .dma_out_ready(dma_out_ready), .busy(busy), .drv_ctl(drv_ctl),
		.drv_status_valid(drv_status_valid), .drv_status(drv_status), .port_active(port_active),
		.drv_wr_valid(drv_wr_valid), .drv_wr_word(drv_wr_word), .drv_wr_last(drv_wr_last),
		.drv_wr_ready(drv_wr_ready), .drv_rd_valid(drv_rd_valid), .drv_rd_word(drv_rd_word),
		.drv_rd_ready(drv_rd_ready), .ecc_fixed(ecc_fixed), .ecc_fatal(ecc_fatal));
	drive_model u_drive_model (.clock(clock), .rstn(rstn), .drv_ctl(drv_ctl), .drv_wr_valid(drv_wr_valid),
		.drv_wr_word(drv_wr_word), .drv_wr_last(drv_wr_last), .drv_wr_ready(drv_wr_ready),
		.drv_rd_valid(drv_rd_valid), .drv_rd_word(drv_rd_word), .drv_rd_ready(drv_rd_ready),
		.drv_status_valid(drv_status_valid), .drv_status(drv_status), .inj(inj));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) begin
		fixed_n <= fixed_n + int'(ecc_fixed === 1'b1);
		fatal_n <= fatal_n + int'(ecc_fatal === 1'b1);
		acc_n <= acc_n + int'(acc_valid === 1'b1);
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("num_errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic fn(dtc_pkg::func_t f, logic [15:0] p);
		@(posedge clock);
		fn_valid <= 1'b1;
		fn_in <= '{func: f, param: p};
		@(posedge clock);
		fn_valid <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	task automatic idle();
		int k;
		k = 0;
		while ((busy !== 1'b0 || drv_wr_valid !== 1'b0) && k < 400) begin
			@(posedge clock);
			k++;
		end
		if (k >= 400) begin
			num_errors++;
			$display("[FAIL] idle expected 0 seen busy %b", busy);
		end
	endtask
	task automatic push(int n);
		for (int i = 0; i < n; i++) begin
			dma_in_valid <= 1'b1;
			dma_in_data <= 16'(i);
			do @(posedge clock); while (dma_in_ready !== 1'b1);
		end
		dma_in_valid <= 1'b0;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_status();
		int a0;
		chk("port after reset", 16'h0001, 16'(port_active));
		chk("busy after reset", 16'h0000, 16'(busy));
		fn(dtc_pkg::FN_SELECT, 16'h0001);
		chk("ctl func", 16'h0001, 16'(u_drive_model.ctl_q.func));
		chk("ctl unit", 16'h0001, 16'(u_drive_model.ctl_q.unit));
		a0 = acc_n;
		fn(dtc_pkg::FN_STATUS, 16'h0000);
		chk("acc pulses", 16'h0001, 16'(acc_n - a0));
		chk("acc data", 16'hA501, acc_data);
		fn(dtc_pkg::FN_PORT, 16'h0001);
		chk("port switch", 16'h0002, 16'(port_active));
	endtask
	task automatic t_chain();
		fn(dtc_pkg::FN_NOP, 16'h0000);
		fn(dtc_pkg::FN_WRITE, 16'h0045);
		chk("spindle", 16'h0001, 16'(u_drive_model.ctl_q.spindle));
		chk("busy", 16'h0001, 16'(busy));
		fn(dtc_pkg::FN_PORT, 16'h0000);
		push(4096);
		idle();
		chk("port kept", 16'h0002, 16'(port_active));
		chk("words", 16'd4096, 16'(u_drive_model.wn));
		chk("packets", 16'd256, 16'(u_drive_model.lasts));
	endtask
	task automatic t_defect();
		fn(dtc_pkg::FN_SEEK, 16'h800A);
		fn(dtc_pkg::FN_WRITE, 16'h0000);
		push(2048);
		idle();
		chk("words", 16'd2056, 16'(u_drive_model.wn));
		for (int k = 10; k < 18; k++) chk("zero run", 16'h0000, u_drive_model.mem[k].data);
		chk("before run", 16'h0009, u_drive_model.mem[9].data);
		chk("after run", 16'h000A, u_drive_model.mem[18].data);
	endtask
	task automatic t_read();
		int k, g;
		k = 0;
		g = 0;
		inj <= 1'b1;
		fn(dtc_pkg::FN_READ, 16'h0000);
		while (k < 2048 && g < 20000) begin
			@(posedge clock);
			if (dma_out_valid === 1'b1 && dma_out_ready === 1'b1) begin
				rd_buf[k] = dma_out_data;
				k++;
			end
			dma_out_ready <= (g % 5 != 0);
			g++;
		end
		dma_out_ready <= 1'b0;
		inj <= 1'b0;
		idle();
		for (int i = 0; i < 2048; i++) if (i != 4) chk("read data", 16'(i), rd_buf[i]);
		chk("fixed", 16'h0001, 16'(fixed_n));
		chk("fatal", 16'h0001, 16'(fatal_n));
	endtask
	task automatic t_format();
		fn(dtc_pkg::FN_FORMAT, 16'h0000);
		push(2048);
		idle();
		chk("id word", 16'h800A, u_drive_model.mem[0].data);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rstn, fn_valid, dma_in_valid, dma_out_ready, inj} = 5'h00;
		{fn_in, dma_in_data} = '0;
		acc_chan = 2'h1;
		{num_errors, compares, fixed_n, fatal_n, acc_n} = '0;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		t_status();
		t_chain();
		t_defect();
		t_read();
		t_format();
		give_verdict();
	end
	initial begin
		repeat (60000) @(posedge clock);
		num_errors++;
		$display("[FAIL] watchdog expected finish seen timeout");
		give_verdict();
	end
endmodule

// ---- verilog/disk_track_controller.sv ----
// Disk control unit datapath and sequencer between the channel and the drives.
`timescale 1ns/1ps

// Summary of operation
// - Data moves in packets of sixteen parcels.
// - Decode channel functions into drive control signals.
// - Capture drive status, return on status function.
// - One DMA port, one accumulator output; acc_chan is not decoded.
// - Drive side handles deskew and assembly.
// - Transfer only whole 2048-parcel sectors.
// - Consecutive sectors chain into one operation.
// - Eight spindles as two four-spindle drives.
// - Control and status only for selected drive.
// - Stage data in a full-track buffer.
// - Generate check bits on write data.
// - Check and correct read data.
// - Track of 48 sectors, 12 per spindle.
// - Write zero run at defect address.
// - Drop zero run on read.
// - Record defect parameter in sector ID.
// - Two drive ports, one active.
module disk_track_controller (
	input wire logic clock,
	input wire logic rstn,
	input wire logic fn_valid,
	input wire dtc_pkg::chan_func_t fn_in,
	input wire logic [1:0] acc_chan,
	output logic [15:0] acc_data,
	output logic acc_valid,
	input wire logic dma_in_valid,
	input wire logic [15:0] dma_in_data,
	output logic dma_in_ready,
	output logic dma_out_valid,
	output logic [15:0] dma_out_data,
	input wire logic dma_out_ready,
	output logic busy,
	output dtc_pkg::drive_ctl_t drv_ctl,
	input wire logic drv_status_valid,
	input wire logic [15:0] drv_status,
	output logic [1:0] port_active,
	output logic drv_wr_valid,
	output dtc_pkg::coded_t drv_wr_word,
	output logic drv_wr_last,
	input wire logic drv_wr_ready,
	input wire logic drv_rd_valid,
	input wire dtc_pkg::coded_t drv_rd_word,
	output logic drv_rd_ready,
	output logic ecc_fixed,
	output logic ecc_fatal
);
	// ****************************************
	// Check code
	// ****************************************
	// Hamming code over 16 data bits, five check bits plus overall parity.
	function automatic logic [4:0] syn_bits(input logic [15:0] d);
		logic [20:0] cw;
		logic [4:0] s;
		int k;
		int p;
		cw = '0;
		s = '0;
		k = 0;
		for (p = 1; p <= 21; p++) begin
			if ((p & (p - 1)) != 0) begin
				cw[p - 1] = d[k];
				k++;
			end
		end
		for (p = 1; p <= 21; p++) begin
			s = s ^ (cw[p - 1] ? 5'(p) : 5'h00);
		end
		return s;
	endfunction

	function automatic logic [5:0] ecc_gen(input logic [15:0] d);
		logic [4:0] s;
		s = syn_bits(d);
		return {^{d, s}, s};
	endfunction

	// Map a codeword position back to its data bit, or 16 for a check bit.
	function automatic logic [4:0] data_index(input logic [4:0] pos);
		logic [4:0] idx;
		int p;
		int k;
		idx = 5'h10;
		k = 0;
		for (p = 1; p <= 21; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (5'(p) == pos) begin
					idx = 5'(k);
				end
				k++;
			end
		end
		return idx;
	endfunction

	// ****************************************
	// State
	// ****************************************
	typedef enum {
		ST_IDLE,
		ST_ID,
		ST_WRITE,
		ST_ZERO,
		ST_READ
	} state_t;

	typedef struct packed {
		state_t st;
		logic unit;
		logic port;
		logic [1:0] spindle;
		logic [3:0] sect;
		logic [5:0] sector_no;
		logic [15:0] count;
		logic [10:0] parcel;
		logic [3:0] pkt;
		logic [3:0] zcnt;
		logic [10:0] defect;
		logic defect_en;
		logic chain;
		logic [15:0] status;
		logic [15:0] acc_data;
		logic acc_valid;
		dtc_pkg::drive_ctl_t ctl;
		logic [1:0] port_active;
		logic wr_valid;
		dtc_pkg::coded_t wr_word;
		logic wr_last;
		logic in_ready;
		logic rd_ready;
		logic [1:0] bvalid;
		logic [1:0][15:0] bdata;
		logic out_valid;
		logic [15:0] out_data;
		logic fixed;
		logic fatal;
		logic busy;
	} regs_t;

	regs_t q;
	regs_t d;
	// Full-track staging memory shared by reads and writes.
	logic [15:0] track_mem [dtc_pkg::TRACK_PARCELS];
	logic [16:0] waddr;
	logic mem_we;
	logic [15:0] mem_wdata;
	logic [4:0] syn;
	logic parity_err;
	logic [15:0] fixed_data;
	logic [4:0] bit_idx;
	logic sector_done;

	always_comb begin
		waddr = 17'({q.sector_no, q.parcel});
		syn = syn_bits(drv_rd_word.data) ^ drv_rd_word.ecc[4:0];
		parity_err = ^{drv_rd_word.data, drv_rd_word.ecc};
		bit_idx = data_index(syn);
		fixed_data = drv_rd_word.data;
		if (parity_err && syn != 5'h00 && bit_idx != 5'h10) begin
			fixed_data[bit_idx[3:0]] = ~fixed_data[bit_idx[3:0]];
		end
	end

	always_comb begin
		d = q;
		mem_we = 1'b0;
		mem_wdata = '0;
		d.acc_valid = 1'b0;
		d.ctl.valid = 1'b0;
		d.fixed = 1'b0;
		d.fatal = 1'b0;
		sector_done = 1'b0;
		// Two-entry buffer ahead of the DMA output; consumer pops first.
		if (q.out_valid && dma_out_ready) begin
			d.out_valid = 1'b0;
		end
		if (!d.out_valid && q.bvalid[0]) begin
			d.out_valid = 1'b1;
			d.out_data = q.bdata[0];
			d.bvalid = {1'b0, q.bvalid[1]};
			d.bdata[0] = q.bdata[1];
		end
		// Status is latched from the drive on its own strobe.
		if (drv_status_valid) begin
			d.status = drv_status;
		end
		if (drv_wr_valid && drv_wr_ready) begin
			d.wr_valid = 1'b0;
		end
		case (q.st)
			ST_IDLE: begin
				if (fn_valid) begin
					case (fn_in.func)
						dtc_pkg::FN_SELECT: begin
							d.unit = fn_in.param[0];
						end
						dtc_pkg::FN_PORT: begin
							d.port = fn_in.param[0];
						end
						dtc_pkg::FN_STATUS: begin
							d.acc_data = q.status;
							d.acc_valid = 1'b1;
						end
						dtc_pkg::FN_READ, dtc_pkg::FN_WRITE, dtc_pkg::FN_FORMAT: begin
							d.sector_no = fn_in.param[5:0] > dtc_pkg::TRACK_LAST ? 6'h00 : fn_in.param[5:0];
							d.spindle = d.sector_no[1:0];
							d.sect = d.sector_no[5:2];
							d.count = {8'h00, fn_in.param[13:6]};
							d.chain = fn_in.param[13:6] != 8'h00;
							d.parcel = '0;
							d.pkt = '0;
							d.st = fn_in.func == dtc_pkg::FN_READ ? ST_READ :
								fn_in.func == dtc_pkg::FN_FORMAT ? ST_ID : ST_WRITE;
						end
						default: begin
							d.defect = fn_in.param[10:0];
							d.defect_en = fn_in.param[15];
						end
					endcase
					// Functions reach the selected drive only.
					d.ctl.valid = fn_in.func != dtc_pkg::FN_STATUS && fn_in.func != dtc_pkg::FN_PORT;
					d.ctl.func = fn_in.func;
					d.ctl.unit = fn_in.func == dtc_pkg::FN_SELECT ? fn_in.param[0] : q.unit;
					d.ctl.spindle = d.spindle;
					d.ctl.param = fn_in.param;
				end
			end
			ST_ID: begin
				if (!q.wr_valid || drv_wr_ready) begin
					d.wr_valid = 1'b1;
					d.wr_word = {{q.defect_en, 4'h0, q.defect}, ecc_gen({q.defect_en, 4'h0, q.defect})};
					d.wr_last = 1'b1;
					d.st = ST_WRITE;
				end
			end
			ST_WRITE: begin
				// Stage the word in the track buffer and emit it coded on the same clock edge.
				if (dma_in_valid && q.in_ready && (!q.wr_valid || drv_wr_ready)) begin
					mem_we = 1'b1;
					mem_wdata = dma_in_data;
					d.wr_valid = 1'b1;
					d.wr_word = {dma_in_data, ecc_gen(dma_in_data)};
					d.wr_last = q.pkt == dtc_pkg::LAST_IN_PACKET;
					d.pkt = q.pkt + 4'h1;
					d.parcel = q.parcel + 11'h001;
					if (q.defect_en && q.parcel + 11'h001 == q.defect) begin
						d.st = ST_ZERO;
						d.zcnt = '0;
					end
					sector_done = q.parcel == dtc_pkg::LAST_PARCEL;
				end
			end
			ST_ZERO: begin
				if (!q.wr_valid || drv_wr_ready) begin
					d.wr_valid = 1'b1;
					d.wr_word = {16'h0000, ecc_gen(16'h0000)};
					d.wr_last = 1'b0;
					d.zcnt = q.zcnt + 4'h1;
					if (q.zcnt == dtc_pkg::LAST_ZERO) begin
						d.st = ST_WRITE;
					end
				end
			end
			ST_READ: begin
				if (drv_rd_valid && q.rd_ready) begin
					d.fixed = parity_err && syn != 5'h00;
					d.fatal = !parity_err && syn != 5'h00;
					if (q.defect_en && q.parcel == q.defect && q.zcnt != dtc_pkg::LAST_ZERO + 4'h1) begin
						d.zcnt = q.zcnt + 4'h1;
					end else begin
						mem_we = 1'b1;
						mem_wdata = fixed_data;
						d.bdata[q.bvalid[0] && d.bvalid[0] ? 1 : 0] = fixed_data;
						d.bvalid[q.bvalid[0] && d.bvalid[0] ? 1 : 0] = 1'b1;
						d.parcel = q.parcel + 11'h001;
						sector_done = q.parcel == dtc_pkg::LAST_PARCEL;
					end
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
		if (sector_done) begin
			// Sectors rotate over the four spindles, twelve per spindle.
			d.parcel = '0;
			d.zcnt = '0;
			d.spindle = q.spindle == dtc_pkg::SPIN_LAST ? 2'h0 : q.spindle + 2'h1;
			if (q.spindle == dtc_pkg::SPIN_LAST) begin
				d.sect = q.sect == dtc_pkg::SECT_LAST ? 4'h0 : q.sect + 4'h1;
			end
			d.sector_no = q.sector_no == dtc_pkg::TRACK_LAST ? 6'h00 : q.sector_no + 6'h01;
			if (q.count == 16'h0000) begin
				d.st = ST_IDLE;
				d.chain = 1'b0;
			end else begin
				d.count = q.count - 16'h0001;
			end
		end
		// One drive port active at a time, switched only while idle.
		d.port_active = q.port ? 2'b10 : 2'b01;
		d.in_ready = d.st == ST_WRITE && !d.wr_valid;
		d.rd_ready = d.st == ST_READ && !d.bvalid[1];
		d.busy = d.st != ST_IDLE;
	end

	always_ff @(posedge clock) begin
		if (mem_we) begin
			track_mem[waddr] <= mem_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.port_active <= 2'b01;
		end else begin
			q <= d;
		end
	end

	assign acc_data = q.acc_data;
	assign acc_valid = q.acc_valid;
	assign dma_in_ready = q.in_ready;
	assign dma_out_valid = q.out_valid;
	assign dma_out_data = q.out_data;
	assign busy = q.busy;
	assign drv_ctl = q.ctl;
	assign port_active = q.port_active;
	assign drv_wr_valid = q.wr_valid;
	assign drv_wr_word = q.wr_word;
	assign drv_wr_last = q.wr_last;
	assign drv_rd_ready = q.rd_ready;
	assign ecc_fixed = q.fixed;
	assign ecc_fatal = q.fatal;

	// ****************************************
	// Checks
	// ****************************************
	a_one_port: assert property (@(posedge clock) disable iff (!rstn) $onehot(port_active))
		else $error("more than one drive port active");
	a_port_idle: assert property (@(posedge clock) disable iff (!rstn) busy |-> $stable(q.port))
		else $error("port changed during transfer");
	a_status_out: assert property (@(posedge clock) disable iff (!rstn)
		fn_valid && !busy && fn_in.func == dtc_pkg::FN_STATUS |=> acc_valid && acc_data == $past(q.status))
		else $error("status not returned");
	a_ctl_unit: assert property (@(posedge clock) disable iff (!rstn)
		drv_ctl.valid && drv_ctl.func != dtc_pkg::FN_SELECT |-> drv_ctl.unit == $past(q.unit))
		else $error("control sent to wrong drive");
	a_ecc_gen: assert property (@(posedge clock) disable iff (!rstn)
		drv_wr_valid |-> drv_wr_word.ecc == ecc_gen(drv_wr_word.data))
		else $error("bad check bits on write");
	a_spin_range: assert property (@(posedge clock) disable iff (!rstn) q.sect <= dtc_pkg::SECT_LAST)
		else $error("sector per spindle out of range");
	a_zero_run: assert property (@(posedge clock) disable iff (!rstn)
		q.st == ST_ZERO && (!drv_wr_valid || drv_wr_ready) |=> drv_wr_valid && drv_wr_word.data == 16'h0000)
		else $error("zero run carries data");
	a_sector_end: assert property (@(posedge clock) disable iff (!rstn)
		sector_done |-> q.parcel == dtc_pkg::LAST_PARCEL)
		else $error("sector ended early");
endmodule
